// ### pkg/dmx_defines.vh
/*
  constants for the data-move execution block: opcode prefixes, widths,
  reset values and register offsets.
  assumes inclusion by bare name from the design files.
*/
`ifndef DMX_DEFINES_VH
`define DMX_DEFINES_VH

// ----------------------------------------------------------------
// opcode prefixes (left aligned in the 16-bit instruction word)
// ----------------------------------------------------------------
`define DMX_OP_PAGE_RD 9'h17f
`define DMX_OP_PORT_RD 9'h09e
`define DMX_OP_SER_RD 9'h0be
`define DMX_OP_WR2MEM 4'h7
`define DMX_OP_MEM2WR 5'h0d
`define DMX_OP_TABLE_POINTER_LOW_WR 9'h130
`define DMX_OP_TABLE_POINTER_HIGH_WR 9'h131

// ----------------------------------------------------------------
// widths and derived values
// ----------------------------------------------------------------
`define DMX_NIB_ZERO 4'h0
`define DMX_ROM_PAGE 11'h010
`define DMX_MEM_DEPTH 128

// ----------------------------------------------------------------
// wishbone register offsets and reset values
// ----------------------------------------------------------------
`define DMX_REG_INSN 8'h00
`define DMX_REG_CTRL 8'h04
`define DMX_REG_STATE 8'h08
`define DMX_REG_TABLE 8'h0c
`define DMX_REG_ISTAT 8'h10
`define DMX_REG_IMASK 8'h14
`define DMX_REG_MEM 8'h18
`define DMX_RST_NIB 4'h0
`define DMX_RST_MASK 2'h0

// ----------------------------------------------------------------
// interrupt status bit positions
// ----------------------------------------------------------------
`define DMX_IRQ_DONE 0
`define DMX_IRQ_CHANGE 1

`endif

// ### src/dmx_change_watch.v
/*
  change-watch port: synchronises four pins and keeps one sticky flag
  per pin that goes high on any change of that pin that holds for at least two clock cycles.
  assumes pins come from outside the clock domain; clear is a pulse.
*/
`timescale 1ns/1ps
module dmx_change_watch (
  input wire clk,
  input wire srst,
  input wire [3:0] pin,
  input wire [3:0] clear,
  output reg [3:0] flags,
  output wire change
);

  // ----------------------------------------------------------------
  // three-stage synchronisers with change detect
  // ----------------------------------------------------------------
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync3;
  reg [3:0] stable;
  wire [3:0] edge_seen;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      assign edge_seen[i] = (sync2[i] == sync3[i]) &&
                            (sync3[i] != stable[i]);
      always @(posedge clk) begin
        if (srst) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
          sync3[i] <= 1'b0;
          stable[i] <= 1'b0;
          flags[i] <= 1'b0;
        end else begin
          sync1[i] <= pin[i];
          sync2[i] <= sync1[i];
          sync3[i] <= sync2[i];
          if (edge_seen[i])
            stable[i] <= sync3[i];
          // set wins over clear
          if (edge_seen[i])
            flags[i] <= 1'b1;
          else if (clear[i])
            flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign change = |edge_seen;

endmodule // dmx_change_watch

// ### src/dmx_data_mem.v
/*
  128 x 4 data memory built from flip-flops, one write port and two
  asynchronous read ports.
  assumes one write per clock.
*/
`timescale 1ns/1ps
`include "dmx_defines.vh"
module dmx_data_mem (
  input wire clk,
  input wire srst,
  input wire we,
  input wire [6:0] waddr,
  input wire [3:0] wdata,
  input wire [6:0] raddr_a,
  output wire [3:0] rdata_a,
  input wire [6:0] raddr_b,
  output wire [3:0] rdata_b
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [3:0] mem [0:`DMX_MEM_DEPTH-1];
  integer k;

  always @(posedge clk) begin
    if (srst) begin
      for (k = 0; k < `DMX_MEM_DEPTH; k = k + 1)
        mem[k] <= `DMX_RST_NIB;
    end else if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule // dmx_data_mem

// ### src/dmx_exec.v
/*
  data-move instruction execution unit with a wishbone register slave.
  software writes an instruction word; it runs in one clock cycle.
  assumes a classic wishbone master and asynchronous change-watch pins.
*/
// Overview of operation
// - the page-register read copies the page select register to the accumulator and the addressed word in one cycle and updates the zero flag.
// - the port-change read copies the change flags to the accumulator and the addressed word in one cycle and updates the zero flag.
// - each change flag reads one after a change on its pin that holds for at least two clock cycles, until a port-change read clears it, and zero otherwise.
// - the serial-status read copies the serial port flags to the accumulator and the addressed word in one cycle and updates the zero flag.
// - the register-to-memory move copies the selected working register to the accumulator and the addressed word in one cycle and updates the zero flag.
// - the memory-to-register move loads the addressed word into the selected working register and the accumulator in one cycle and updates the zero flag.
// - the low table pointer write loads the addressed word into the low pointer and leaves accumulator and flags alone.
// - the high table pointer write loads the addressed word into the high pointer and leaves accumulator and flags alone.
// - the look-up address is the high pointer times sixteen plus the low pointer.
`timescale 1ns/1ps
`include "dmx_defines.vh"
module dmx_exec (
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:0] change_watch_port,
  input wire [3:0] serial_port_flags,
  output reg [10:0] table_rom_addr,
  output wire irq
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function is_zero;
    input [3:0] v;
    begin
      is_zero = (v == `DMX_NIB_ZERO);
    end
  endfunction

  // ----------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------
  reg [3:0] accumulator;
  reg zero_flag;
  reg [3:0] page_select_register;
  reg [3:0] table_pointer_low;
  reg [3:0] table_pointer_high;
  reg [15:0] last_insn;
  reg illegal;
  reg [1:0] int_status;
  reg [1:0] int_mask;
  reg [6:0] mem_peek_addr;

  wire [3:0] port_change_flags;
  wire port_change_event;
  reg [3:0] flag_clear;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire lane0 = wb_sel_i[0];
  wire lane1 = wb_sel_i[1];
  wire insn_go = bus_wr && (wb_adr_i == `DMX_REG_INSN) && lane0 && lane1;
  wire [15:0] insn = wb_dat_i[15:0];
  wire [6:0] maddr = insn[6:0];
  wire [3:0] wsel = insn[10:7];

  // ----------------------------------------------------------------
  // data memory: working registers are words 0..15
  // ----------------------------------------------------------------
  wire [3:0] mem_word;
  wire [3:0] wr_word;
  wire [3:0] peek_word;
  reg mem_we;
  reg [6:0] mem_waddr;
  reg [3:0] mem_wdata;

  dmx_data_mem i_dmx_data_mem (
    .clk(clk),
    .srst(srst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(maddr),
    .rdata_a(mem_word),
    .raddr_b(insn_go ? {3'h0, wsel} : mem_peek_addr),
    .rdata_b(wr_word)
  );

  assign peek_word = wr_word;

  dmx_change_watch i_dmx_change_watch (
    .clk(clk),
    .srst(srst),
    .pin(change_watch_port),
    .clear(flag_clear),
    .flags(port_change_flags),
    .change(port_change_event)
  );

  // ----------------------------------------------------------------
  // instruction execute
  // ----------------------------------------------------------------
  reg [3:0] next_acc;
  reg next_acc_load;
  reg next_table_pointer_low_load;
  reg next_table_pointer_high_load;
  reg next_illegal;

  always @* begin
    next_acc = accumulator;
    next_acc_load = 1'b0;
    next_table_pointer_low_load = 1'b0;
    next_table_pointer_high_load = 1'b0;
    next_illegal = 1'b0;
    mem_we = 1'b0;
    mem_waddr = maddr;
    mem_wdata = `DMX_NIB_ZERO;
    flag_clear = 4'h0;
    if (insn_go) begin
      if (insn[15:7] == `DMX_OP_PAGE_RD) begin
        next_acc = page_select_register;
        next_acc_load = 1'b1;
        mem_we = 1'b1;
        mem_wdata = page_select_register;
      end else if (insn[15:7] == `DMX_OP_PORT_RD) begin
        next_acc = port_change_flags;
        next_acc_load = 1'b1;
        mem_we = 1'b1;
        mem_wdata = port_change_flags;
        flag_clear = port_change_flags;
      end else if (insn[15:7] == `DMX_OP_SER_RD) begin
        next_acc = serial_port_flags;
        next_acc_load = 1'b1;
        mem_we = 1'b1;
        mem_wdata = serial_port_flags;
      end else if (insn[15:7] == `DMX_OP_TABLE_POINTER_LOW_WR) begin
        next_table_pointer_low_load = 1'b1;
      end else if (insn[15:7] == `DMX_OP_TABLE_POINTER_HIGH_WR) begin
        next_table_pointer_high_load = 1'b1;
      end else if (insn[15:12] == `DMX_OP_WR2MEM) begin
        next_acc = wr_word;
        next_acc_load = 1'b1;
        mem_we = 1'b1;
        mem_wdata = wr_word;
      end else if (insn[15:11] == `DMX_OP_MEM2WR) begin
        next_acc = mem_word;
        next_acc_load = 1'b1;
        mem_we = 1'b1;
        mem_waddr = {3'h0, wsel};
        mem_wdata = mem_word;
      end else begin
        next_illegal = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  wire wr_ctrl = bus_wr && (wb_adr_i == `DMX_REG_CTRL) && lane0;
  wire wr_istat = bus_wr && (wb_adr_i == `DMX_REG_ISTAT) && lane0;
  wire wr_imask = bus_wr && (wb_adr_i == `DMX_REG_IMASK) && lane0;
  wire wr_peek = bus_wr && (wb_adr_i == `DMX_REG_MEM) && lane0;
  wire [1:0] irq_set = {port_change_event, insn_go};

  always @(posedge clk) begin
    if (srst) begin
      accumulator <= `DMX_RST_NIB;
      zero_flag <= 1'b0;
      page_select_register <= `DMX_RST_NIB;
      table_pointer_low <= `DMX_RST_NIB;
      table_pointer_high <= `DMX_RST_NIB;
      last_insn <= 16'h0000;
      illegal <= 1'b0;
      int_status <= `DMX_RST_MASK;
      int_mask <= `DMX_RST_MASK;
      mem_peek_addr <= 7'h00;
      table_rom_addr <= 11'h000;
    end else begin
      if (next_acc_load) begin
        accumulator <= next_acc;
        zero_flag <= is_zero(next_acc);
      end
      if (next_table_pointer_low_load)
        table_pointer_low <= mem_word;
      if (next_table_pointer_high_load)
        table_pointer_high <= mem_word;
      table_rom_addr <= {7'h00, table_pointer_high} * `DMX_ROM_PAGE +
                        {7'h00, table_pointer_low};
      if (insn_go) begin
        last_insn <= insn;
        illegal <= next_illegal;
      end
      if (wr_ctrl)
        page_select_register <= wb_dat_i[3:0];
      if (wr_imask)
        int_mask <= wb_dat_i[1:0];
      if (wr_peek)
        mem_peek_addr <= wb_dat_i[6:0];
      // set wins over write-one-to-clear
      if (wr_istat)
        int_status <= (int_status & ~wb_dat_i[1:0]) | irq_set;
      else
        int_status <= int_status | irq_set;
    end
  end

  assign irq = |(int_status & int_mask);

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `DMX_REG_INSN: wb_dat_o <= {16'h0000, last_insn};
          `DMX_REG_CTRL: wb_dat_o <= {28'h0000000, page_select_register};
          `DMX_REG_STATE: wb_dat_o <= {18'h00000, illegal, zero_flag,
                                      serial_port_flags,
                                      port_change_flags, accumulator};
          `DMX_REG_TABLE: wb_dat_o <= {13'h0000, table_rom_addr,
                                      table_pointer_high,
                                      table_pointer_low};
          `DMX_REG_ISTAT: wb_dat_o <= {30'h00000000, int_status};
          `DMX_REG_IMASK: wb_dat_o <= {30'h00000000, int_mask};
          `DMX_REG_MEM: wb_dat_o <= {21'h000000, mem_peek_addr,
                                    peek_word};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // dmx_exec

// ### tb/dmx_exec_properties.sv
/*
  port checker for the data-move execution unit.
  assumes it is bound to dmx_exec; one clock, srst synchronous.
*/
`timescale 1ns/1ps
module dmx_exec_properties (
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [3:0] change_watch_port,
  input wire [3:0] serial_port_flags,
  input wire [10:0] table_rom_addr,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire req = wb_cyc_i & wb_stb_i;
  wire take = req & ~wb_ack_o;
  a_ack_answer: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_rom_range: assert property (table_rom_addr[10:8] == 3'h0)
    else $error("rom address above pointer range");
  a_rom_cause: assert property (!$stable(table_rom_addr) |->
    $past(srst) || $past(take & wb_we_i & (wb_adr_i == 8'h00), 2))
    else $error("rom address moved without instruction");
  a_unmapped_zero: assert property (take & !wb_we_i & (wb_adr_i == 8'h1c)
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_table_sum: assert property (take & !wb_we_i & (wb_adr_i == 8'h0c)
    |=> wb_dat_o[18:8] == {3'h0, wb_dat_o[7:4], wb_dat_o[3:0]})
    else $error("rom address not high*16+low");
  a_table_port: assert property (take & !wb_we_i & (wb_adr_i == 8'h0c)
    |=> wb_dat_o[18:8] == table_rom_addr)
    else $error("table read differs from rom port");
  cover property (take & wb_we_i & (wb_adr_i == 8'h00));
  cover property (irq);
  cover property (!$stable(table_rom_addr));
endmodule // dmx_exec_properties

bind dmx_exec dmx_exec_properties i_dmx_exec_properties (.clk(clk),
  .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .change_watch_port(change_watch_port),
  .serial_port_flags(serial_port_flags), .table_rom_addr(table_rom_addr),
  .irq(irq));

// ### tb/dmx_exec_test.sv
/*
  self-checking bench for the data-move execution unit.
  assumes the checker is bound to dmx_exec.
*/
`timescale 1ns/1ps
module dmx_exec_test;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, cwp = 4'h0, spf = 4'h0;
  logic [31:0] dat = 32'h0, q;
  wire [31:0] dat_o;
  wire ack, irq;
  wire [10:0] rom;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  always #2.5 clk = ~clk;
  dmx_exec i_dmx_exec (.clk(clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .change_watch_port(cwp), .serial_port_flags(spf),
    .table_rom_addr(rom), .irq(irq));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      miscompares++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task ex(input logic [15:0] i);
    wb(1'b1, 8'h00, {16'h0, i});
  endtask
  task st(input logic [3:0] acc, input logic z);
    wb(1'b0, 8'h08, 32'h0);
    chk({26'h0, q[13:12], q[3:0]}, {26'h0, 1'b0, z, acc}, "acc/zero");
  endtask
  task pk(input logic [6:0] a, input logic [3:0] v);
    wb(1'b1, 8'h18, {25'h0, a});
    wb(1'b0, 8'h18, 32'h0);
    chk({21'h0, q[10:0]}, {21'h0, a, v}, "memory word");
  endtask
  task irqchk(input logic e);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, e}, "irq level");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [7:0] offs [7];
    offs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
    foreach (offs[k]) begin
      wb(1'b0, offs[k], 32'h0);
      chk(q, 32'h0, "reset value");
    end
    chk({21'h0, rom}, 32'h0, "rom reset");
    $display("t_reset done");
  endtask
  task t_moves;
    wb(1'b1, 8'h04, 32'h5);
    ex({9'h17f, 7'h20});
    st(4'h5, 1'b0);
    pk(7'h20, 4'h5);
    spf <= 4'ha;
    ex({9'h0be, 7'h21});
    st(4'ha, 1'b0);
    pk(7'h21, 4'ha);
    ex({5'h0d, 4'h3, 7'h21});
    st(4'ha, 1'b0);
    pk(7'h03, 4'ha);
    wb(1'b1, 8'h04, 32'h0);
    ex({9'h17f, 7'h25});
    st(4'h0, 1'b1);
    ex({4'h7, 1'b0, 4'h3, 7'h22});
    st(4'ha, 1'b0);
    pk(7'h22, 4'ha);
    $display("t_moves done");
  endtask
  task t_table;
    ex({9'h17f, 7'h25});
    ex({9'h130, 7'h21});
    ex({9'h131, 7'h20});
    st(4'h0, 1'b1);
    wb(1'b0, 8'h0c, 32'h0);
    chk({13'h0, q[18:0]}, {13'h0, 11'h05a, 4'h5, 4'ha}, "pointers");
    chk({21'h0, rom}, {21'h0, 11'h05a}, "rom port");
    ex({9'h131, 7'h25});
    wb(1'b0, 8'h0c, 32'h0);
    chk({13'h0, q[18:0]}, {13'h0, 11'h00a, 4'h0, 4'ha}, "pointers");
    chk({21'h0, rom}, {21'h0, 11'h00a}, "rom port");
    $display("t_table done");
  endtask
  task t_change;
    wb(1'b1, 8'h14, 32'h2);
    wb(1'b1, 8'h10, 32'h3);
    irqchk(1'b0);
    cwp <= 4'h5;
    repeat (10) @(posedge clk);
    wb(1'b0, 8'h10, 32'h0);
    chk({31'h0, q[1]}, 32'h1, "change status");
    irqchk(1'b1);
    ex({9'h09e, 7'h26});
    st(4'h5, 1'b0);
    pk(7'h26, 4'h5);
    ex({9'h09e, 7'h27});
    st(4'h0, 1'b1);
    wb(1'b1, 8'h14, 32'h0);
    irqchk(1'b0);
    wb(1'b1, 8'h14, 32'h3);
    irqchk(1'b1);
    wb(1'b1, 8'h10, 32'h3);
    irqchk(1'b0);
    $display("t_change done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_moves;
    t_table;
    t_change;
    test_done;
  end
endmodule // dmx_exec_test
